// File: core/fps_top.sv
// Overview of operation
// - Power from positive-sequence fundamental voltage and current, immune to asymmetry.
// - Accurate method averages power over the latest 16 cycles, sliding.
// - Fast method uses single-cycle positive-sequence power for quicker response.
// - Low stage picks up below its threshold, high stage above its own.
// - Each stage has a delay timer from pickup; trip only after expiry.
// - Each stage has its own block input suppressing only that stage.
// - A further block input suppresses the whole function.
// - Broken wire, voltage failure or VT breaker trip block the low stage.
// - Modes off, on, block-command; block-command indicates but suppresses commands.
// - Function inactive and settings inaccessible unless enabled in scope.
// - Infinite delay never trips but still shows pickup.
// - Delays add to the measuring time; averaging makes response longer.
// - Thresholds in secondary watts at measuring location, else per-unit of side.
// - Accurate method applies a correction angle for transformer angle errors.
// - Status off, blocked, active, plus pickup and trip per stage.
`timescale 1ns/1ns
`default_nettype none

module fps_top
  import fps_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input  wire logic            CLK,
  input  wire logic            RESET,
  input  wire logic            SCOPE_ENABLE,
  input  wire logic            BLOCK_ALL,
  input  wire logic            BLOCK_LOW,
  input  wire logic            BLOCK_HIGH,
  input  wire logic            BROKEN_WIRE,
  input  wire logic            VMEAS_FAIL,
  input  wire logic            VT_BREAKER_TRIP,
  input  wire logic            MEAS_VALID,
  input  wire fps_phasor_type  MEAS,
  input  wire logic [7:0]      S_AXI_AWADDR,
  input  wire logic            S_AXI_AWVALID,
  output logic                 S_AXI_AWREADY,
  input  wire logic [31:0]     S_AXI_WDATA,
  input  wire logic [3:0]      S_AXI_WSTRB,
  input  wire logic            S_AXI_WVALID,
  output logic                 S_AXI_WREADY,
  output logic [1:0]           S_AXI_BRESP,
  output logic                 S_AXI_BVALID,
  input  wire logic            S_AXI_BREADY,
  input  wire logic [7:0]      S_AXI_ARADDR,
  input  wire logic            S_AXI_ARVALID,
  output logic                 S_AXI_ARREADY,
  output logic [31:0]          S_AXI_RDATA,
  output logic [1:0]           S_AXI_RRESP,
  output logic                 S_AXI_RVALID,
  input  wire logic            S_AXI_RREADY,
  output logic                 STAT_OFF,
  output logic                 STAT_BLOCKED,
  output logic                 STAT_ACTIVE,
  output logic                 LOW_PICKUP,
  output logic                 HIGH_PICKUP,
  output logic                 LOW_TRIP,
  output logic                 HIGH_TRIP
);

  localparam int TW = $clog2(TICK_LEN + 1);

  if (TICK_LEN < 2) begin : g_chk
    $error("TICK_LEN must be at least 2");
  end

  // Byte-enable merge for register writes
  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Per-unit Q16 threshold scaled by nominal watts, or taken as watts
  function automatic logic signed [31:0] eff_thr(input logic [31:0] thr,
                                                 input logic        watts,
                                                 input logic [15:0] nom);
    logic signed [48:0] prod;
    prod = $signed(thr) * $signed({1'b0, nom});
    return watts ? $signed(thr) : prod[47:16];
  endfunction

  logic [6:0]          pin_meta;
  logic [6:0]          pin_sync;
  logic [31:0]         reg_ctrl;
  logic [31:0]         reg_low_thr;
  logic [31:0]         reg_high_thr;
  logic [31:0]         reg_low_dly;
  logic [31:0]         reg_high_dly;
  logic [31:0]         reg_corr;
  logic [31:0]         reg_nom;
  logic [TW-1:0]       tick_cnt;
  logic                tick;
  logic                power_valid;
  logic signed [31:0]  power;
  fps_stage_type       state [2];
  fps_stage_type       next_state [2];
  logic [15:0]         cnt [2];
  wire  [15:0]         dly [2];
  wire  [1:0]          cond;

  // Two-flop synchronisers for every pin input
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pin_meta <= {VT_BREAKER_TRIP, VMEAS_FAIL, BROKEN_WIRE, BLOCK_HIGH,
                   BLOCK_LOW, BLOCK_ALL, SCOPE_ENABLE};
      pin_sync <= pin_meta;
    end
  end

  // Mode and blocking decode
  wire       scope     = pin_sync[PIN_SCOPE];
  wire [1:0] mode_bits = reg_ctrl[CTRL_MODE_LSB +: 2];
  wire       mode_on   = scope && (mode_bits == FPS_MODE_ON);
  wire       mode_bcmd = scope && (mode_bits == FPS_MODE_BLKCMD);
  wire       enabled   = mode_on || mode_bcmd;
  wire       blk_all   = pin_sync[PIN_BLK_ALL];
  wire       live      = enabled && !blk_all;
  wire       vt_fail   = pin_sync[PIN_WIRE] || pin_sync[PIN_VMEAS] || pin_sync[PIN_VTBRK];
  wire       fast      = reg_ctrl[CTRL_METHOD_BIT];
  wire       loc_watts = reg_ctrl[CTRL_LOC_BIT];

  // Effective thresholds
  wire signed [31:0] thr_low  = eff_thr(reg_low_thr, loc_watts, reg_nom[15:0]);
  wire signed [31:0] thr_high = eff_thr(reg_high_thr, loc_watts, reg_nom[15:0]);

  // Stage pickup conditions on the measured (possibly averaged) power
  assign cond[0] = live && !pin_sync[PIN_BLK_LOW] && !vt_fail
                   && (power < thr_low);
  assign cond[1] = live && !pin_sync[PIN_BLK_HIGH] && (power > thr_high);
  assign dly[0]  = reg_low_dly[15:0];
  assign dly[1]  = reg_high_dly[15:0];

  // Power measurement and averaging
  fps_power #(
    .AVG_DEPTH (AVG_CYCLES)
  ) u_power (
    .clk         (CLK),
    .reset       (RESET),
    .in_valid    (MEAS_VALID),
    .in_ph       (MEAS),
    .fast        (fast),
    .corr_cos    (reg_corr[15:0]),
    .corr_sin    (reg_corr[31:16]),
    .power_valid (power_valid),
    .power       (power)
  );

  // Millisecond tick for the delay timers
  always_ff @(posedge CLK) begin
    if (RESET || tick_cnt == TW'(TICK_LEN - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    tick <= !RESET && (tick_cnt == TW'(TICK_LEN - 1));
  end

  // Stage timers; first period may be short by up to one tick
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      next_state[s] = state[s];
      case (state[s])
        FPS_ST_IDLE: begin
          if (cond[s]) next_state[s] = FPS_ST_TIMING;
        end
        FPS_ST_TIMING: begin
          if (!cond[s]) begin
            next_state[s] = FPS_ST_IDLE;
          end else if (dly[s] != DELAY_INFINITE && cnt[s] >= dly[s]) begin
            next_state[s] = FPS_ST_TRIPPED;
          end
        end
        // Delay raised to infinity while tripped must withdraw the command
        FPS_ST_TRIPPED: begin
          if (!cond[s] || dly[s] == DELAY_INFINITE) next_state[s] = FPS_ST_IDLE;
        end
        default: next_state[s] = FPS_ST_IDLE;
      endcase
    end
  end

  // Counting starts only once measured power crosses, so delay adds on
  always_ff @(posedge CLK) begin
    for (int s = 0; s < 2; s++) begin
      if (RESET) begin
        state[s] <= FPS_ST_IDLE;
        cnt[s]   <= 16'h0000;
      end else begin
        state[s] <= next_state[s];
        if (state[s] == FPS_ST_IDLE) begin
          cnt[s] <= 16'h0000;
        end else if (tick && cnt[s] != 16'hFFFF) begin
          cnt[s] <= cnt[s] + 16'h0001;
        end
      end
    end
  end

  // Indications; block-command keeps pickups but drops trips
  always_ff @(posedge CLK) begin
    if (RESET) begin
      STAT_OFF     <= 1'b1;
      STAT_BLOCKED <= 1'b0;
      STAT_ACTIVE  <= 1'b0;
      LOW_PICKUP   <= 1'b0;
      HIGH_PICKUP  <= 1'b0;
      LOW_TRIP     <= 1'b0;
      HIGH_TRIP    <= 1'b0;
    end else begin
      STAT_OFF     <= !enabled;
      STAT_BLOCKED <= enabled && blk_all;
      STAT_ACTIVE  <= live;
      LOW_PICKUP   <= cond[0];
      HIGH_PICKUP  <= cond[1];
      LOW_TRIP     <= cond[0] && state[0] == FPS_ST_TRIPPED && mode_on;
      HIGH_TRIP    <= cond[1] && state[1] == FPS_ST_TRIPPED && mode_on;
    end
  end

  // AXI write path: both channels taken together, either may come first
  wire wr_go   = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
  wire wr_fire = S_AXI_AWREADY && S_AXI_AWVALID && S_AXI_WREADY && S_AXI_WVALID;
  wire wr_map  = S_AXI_AWADDR inside {ADDR_CTRL, ADDR_LOW_THR, ADDR_HIGH_THR,
                 ADDR_LOW_DLY, ADDR_HIGH_DLY, ADDR_CORR, ADDR_NOM};
  wire wr_ok   = wr_map && scope;
  wire [31:0] wd = S_AXI_WDATA;
  wire [3:0]  ws = S_AXI_WSTRB;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= wr_go;
      S_AXI_WREADY  <= wr_go;
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Setting registers; locked while the function is not in scope
  always_ff @(posedge CLK) begin
    if (RESET) begin
      reg_ctrl     <= RST_CTRL;
      reg_low_thr  <= RST_LOW_THR;
      reg_high_thr <= RST_HIGH_THR;
      reg_low_dly  <= RST_DLY;
      reg_high_dly <= RST_DLY;
      reg_corr     <= RST_CORR;
      reg_nom      <= RST_NOM;
    end else if (wr_fire && wr_ok) begin
      case (S_AXI_AWADDR)
        ADDR_CTRL:     reg_ctrl     <= apply_strb(reg_ctrl, wd, ws) & CTRL_MASK;
        ADDR_LOW_THR:  reg_low_thr  <= apply_strb(reg_low_thr, wd, ws);
        ADDR_HIGH_THR: reg_high_thr <= apply_strb(reg_high_thr, wd, ws);
        ADDR_LOW_DLY:  reg_low_dly  <= apply_strb(reg_low_dly, wd, ws) & DLY_MASK;
        ADDR_HIGH_DLY: reg_high_dly <= apply_strb(reg_high_dly, wd, ws) & DLY_MASK;
        ADDR_CORR:     reg_corr     <= apply_strb(reg_corr, wd, ws);
        ADDR_NOM:      reg_nom      <= apply_strb(reg_nom, wd, ws) & NOM_MASK;
        default: ;
      endcase
    end
  end

  // AXI read path
  wire [31:0] status_word = {25'h000_0000, HIGH_TRIP, LOW_TRIP, HIGH_PICKUP,
                             LOW_PICKUP, STAT_ACTIVE, STAT_BLOCKED, STAT_OFF};
  wire        rd_map = S_AXI_ARADDR inside {ADDR_CTRL, ADDR_LOW_THR, ADDR_HIGH_THR,
                       ADDR_LOW_DLY, ADDR_HIGH_DLY, ADDR_CORR, ADDR_NOM,
                       ADDR_STATUS, ADDR_POWER};
  wire        rd_ok  = rd_map && scope;
  logic [31:0] rd_mux;

  always_comb begin
    case (S_AXI_ARADDR)
      ADDR_CTRL:     rd_mux = reg_ctrl;
      ADDR_LOW_THR:  rd_mux = reg_low_thr;
      ADDR_HIGH_THR: rd_mux = reg_high_thr;
      ADDR_LOW_DLY:  rd_mux = reg_low_dly;
      ADDR_HIGH_DLY: rd_mux = reg_high_dly;
      ADDR_CORR:     rd_mux = reg_corr;
      ADDR_NOM:      rd_mux = reg_nom;
      ADDR_STATUS:   rd_mux = status_word;
      ADDR_POWER:    rd_mux = power;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_ok ? rd_mux : 32'h0000_0000;
        S_AXI_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  AST_OFF_QUIET: assert property (@(posedge CLK) disable iff (RESET)
    !enabled [*2] |-> STAT_OFF && !LOW_PICKUP && !HIGH_PICKUP && !LOW_TRIP && !HIGH_TRIP)
    else $error("indication while function off");

  AST_TRIP_NEEDS_PICKUP: assert property (@(posedge CLK) disable iff (RESET)
    $rose(LOW_TRIP) |-> LOW_PICKUP && $past(state[0] == FPS_ST_TRIPPED))
    else $error("low trip without expired timer");

  AST_INF_NO_TRIP: assert property (@(posedge CLK) disable iff (RESET)
    (dly[1] == DELAY_INFINITE) [*3] |-> !HIGH_TRIP)
    else $error("high trip with infinite delay");

  AST_BLKCMD_NO_TRIP: assert property (@(posedge CLK) disable iff (RESET)
    mode_bcmd [*2] |-> !LOW_TRIP && !HIGH_TRIP)
    else $error("trip in block-command mode");

  AST_VT_BLOCKS_LOW: assert property (@(posedge CLK) disable iff (RESET)
    vt_fail [*2] |-> !LOW_PICKUP && state[0] == FPS_ST_IDLE)
    else $error("low stage active during voltage failure");

  AST_STAGE_BLOCK: assert property (@(posedge CLK) disable iff (RESET)
    pin_sync[PIN_BLK_HIGH] |=> !HIGH_PICKUP)
    else $error("high pickup while stage blocked");

  AST_ALL_BLOCK: assert property (@(posedge CLK) disable iff (RESET)
    (enabled && blk_all) [*2] |-> STAT_BLOCKED && !STAT_ACTIVE && !LOW_PICKUP && !HIGH_PICKUP)
    else $error("function not blocked");

  AST_DROP_RESETS: assert property (@(posedge CLK) disable iff (RESET)
    state[1] == FPS_ST_TIMING && !cond[1] |=> state[1] == FPS_ST_IDLE ##1 cnt[1] == 16'h0000)
    else $error("timer not reset on dropout");

endmodule

`default_nettype wire

// File: core/fps_pkg.sv
package fps_pkg;

  // Clock and timer base
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Averaging window in power-system cycles
  localparam int AVG_CYCLES = 16;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_LOW_THR  = 8'h04;
  localparam logic [7:0] ADDR_HIGH_THR = 8'h08;
  localparam logic [7:0] ADDR_LOW_DLY  = 8'h0C;
  localparam logic [7:0] ADDR_HIGH_DLY = 8'h10;
  localparam logic [7:0] ADDR_CORR     = 8'h14;
  localparam logic [7:0] ADDR_NOM      = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;
  localparam logic [7:0] ADDR_POWER    = 8'h20;

  // Control fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_METHOD_BIT = 2;
  localparam int CTRL_LOC_BIT    = 3;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_000F;
  localparam logic [31:0] DLY_MASK   = 32'h0000_FFFF;
  localparam logic [31:0] NOM_MASK   = 32'h0000_FFFF;

  // Reset values
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
  localparam logic [31:0] RST_LOW_THR  = 32'h0000_199A;
  localparam logic [31:0] RST_HIGH_THR = 32'h0000_F333;
  localparam logic [31:0] RST_DLY      = 32'h0000_2710;
  localparam logic [31:0] RST_CORR     = 32'h0000_4000;
  localparam logic [31:0] RST_NOM      = 32'h0000_03E8;

  // Delay code meaning infinity
  localparam logic [15:0] DELAY_INFINITE = 16'hFFFF;

  // Synchronised pin positions
  localparam int PIN_SCOPE = 0;
  localparam int PIN_BLK_ALL = 1;
  localparam int PIN_BLK_LOW = 2;
  localparam int PIN_BLK_HIGH = 3;
  localparam int PIN_WIRE = 4;
  localparam int PIN_VMEAS = 5;
  localparam int PIN_VTBRK = 6;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FPS_MODE_OFF    = 2'h0,
    FPS_MODE_ON     = 2'h1,
    FPS_MODE_BLKCMD = 2'h2
  } fps_mode_type;

  typedef enum logic [2:0] {
    FPS_ST_IDLE    = 3'b001,
    FPS_ST_TIMING  = 3'b010,
    FPS_ST_TRIPPED = 3'b100
  } fps_stage_type;

  // Positive-sequence fundamental phasors, one set per cycle
  typedef struct packed {
    logic signed [15:0] v_re;
    logic signed [15:0] v_im;
    logic signed [15:0] i_re;
    logic signed [15:0] i_im;
  } fps_phasor_type;

endpackage

// File: core/fps_power.sv
`timescale 1ns/1ns
`default_nettype none

module fps_power
  import fps_pkg::*;
#(
  parameter int AVG_DEPTH = AVG_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               in_valid,
  input  wire fps_phasor_type     in_ph,
  input  wire logic               fast,
  input  wire logic signed [15:0] corr_cos,
  input  wire logic signed [15:0] corr_sin,
  output logic                    power_valid,
  output logic signed [31:0]      power
);

  localparam int LOG = $clog2(AVG_DEPTH);

  // Window must be a power of two so the mean is a shift
  if (AVG_DEPTH < 2 || AVG_DEPTH != (1 << LOG)) begin : g_chk
    $error("AVG_DEPTH must be a power of two");
  end

  logic signed [31:0]      ring [AVG_DEPTH];
  logic        [LOG-1:0]   ptr;
  logic signed [31+LOG:0]  sum;
  wire  signed [32:0]      rot_re;
  wire  signed [32:0]      rot_im;
  wire  signed [15:0]      cur_re;
  wire  signed [15:0]      cur_im;
  wire  signed [32:0]      prod;
  wire  signed [31:0]      inst;
  wire  signed [31+LOG:0]  next_sum;

  // Current rotated by the correction angle, Q14 coefficients
  assign rot_re = in_ph.i_re * corr_cos - in_ph.i_im * corr_sin;
  assign rot_im = in_ph.i_re * corr_sin + in_ph.i_im * corr_cos;
  // Fast method skips correction: single-cycle phasors are coarse anyway
  assign cur_re = fast ? in_ph.i_re : rot_re[29:14];
  assign cur_im = fast ? in_ph.i_im : rot_im[29:14];

  // Re(V1 * conj(I1)), halved to fit 32 bits
  assign prod = in_ph.v_re * cur_re + in_ph.v_im * cur_im;
  assign inst = prod[32:1];

  // Sliding sum: add newest, drop the one leaving the window
  assign next_sum = sum + (32+LOG)'(inst) - (32+LOG)'(ring[ptr]);

  // Window kept in both methods so a method switch has no warm-up gap
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < AVG_DEPTH; k++) begin
        ring[k] <= 32'h0000_0000;
      end
      ptr         <= '0;
      sum         <= '0;
      power_valid <= 1'b0;
      power       <= 32'h0000_0000;
    end else begin
      power_valid <= in_valid;
      if (in_valid) begin
        ring[ptr] <= inst;
        ptr       <= ptr + 1'b1;
        sum       <= next_sum;
        power     <= fast ? inst : next_sum[31+LOG:LOG];
      end
    end
  end

  AST_FAST_SINGLE: assert property (@(posedge clk) disable iff (reset)
    in_valid && fast |=> power_valid && power == $past(inst))
    else $error("fast power is not the single-cycle value");

endmodule

`default_nettype wire

// File: bench/fps_meas_model.sv
`timescale 1ns/1ns
`default_nettype none

// Transformer-side source: one phasor set per power-system cycle while go is high
module fps_meas_model
  import fps_pkg::*;
#(
  parameter int PERIOD = 20
) (
  input  wire logic           clk,
  input  wire logic           reset,
  input  wire logic           go,
  input  wire fps_phasor_type ph,
  output logic                meas_valid,
  output fps_phasor_type      meas
);
  int        cnt = 0;
  wire logic fire = go && (cnt == PERIOD - 1);

  initial begin
    meas_valid = 1'b0;
    meas       = '0;
  end

  // Phasors mean something only in the pulse cycle, so they are scrambled elsewhere
  always @(posedge clk) begin
    cnt        <= (reset || !go || fire) ? 0 : cnt + 1;
    meas_valid <= fire && !reset;
    meas       <= fire ? ph : ~meas;
  end
endmodule

`default_nettype wire

// File: bench/test_forward_power_supervision.sv
`timescale 1ns/1ns
`default_nettype none

module test_forward_power_supervision;
  import fps_pkg::*;
  localparam fps_phasor_type p50   = {16'h000A, 16'h0000, 16'h000A, 16'h0000};
  localparam fps_phasor_type p500  = {16'h000A, 16'h0000, 16'h0064, 16'h0000};
  localparam fps_phasor_type p2000 = {16'h0028, 16'h0000, 16'h0064, 16'h0000};
  localparam fps_phasor_type prot  = {16'h0028, 16'h0000, 16'h0000, 16'hFFB0};
  logic           clk = 1'b0, reset = 1'b1, scope = 1'b0, go = 1'b0;
  logic           blk_all = 1'b0, blk_high = 1'b0;
  logic [3:0]     lpin = 4'h0;
  logic [7:0]     awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]    wdata = 32'h0000_0000, rdata;
  logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic           awready, wready, bvalid, arready, rvalid, mv;
  logic [1:0]     bresp, rresp;
  logic [6:0]     st;
  logic [15:0]    seed = 16'h0054;
  fps_phasor_type ph = '0, meas, rp;
  logic [33:0]    rq[$], wq[$];
  int             mismatches = 0, tests_run = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  fps_top #(.TICK_LEN(10)) i_dut (
    .CLK(clk), .RESET(reset), .SCOPE_ENABLE(scope), .BLOCK_ALL(blk_all),
    .BLOCK_LOW(lpin[0]), .BLOCK_HIGH(blk_high), .BROKEN_WIRE(lpin[1]),
    .VMEAS_FAIL(lpin[2]), .VT_BREAKER_TRIP(lpin[3]), .MEAS_VALID(mv), .MEAS(meas),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .STAT_OFF(st[0]), .STAT_BLOCKED(st[1]), .STAT_ACTIVE(st[2]), .LOW_PICKUP(st[3]),
    .HIGH_PICKUP(st[4]), .LOW_TRIP(st[5]), .HIGH_TRIP(st[6])
  );

  fps_meas_model i_src (.clk(clk), .reset(reset), .go(go), .ph(ph), .meas_valid(mv), .meas(meas));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Fast-method power: real part of v times conjugate i, halved
  function automatic logic [31:0] pw(input fps_phasor_type p);
    logic signed [31:0] s;
    s = p.v_re * p.i_re + p.v_im * p.i_im;
    return s >>> 1;
  endfunction

  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic sc(input logic [6:0] e);
    chk("status pins", {27'h000_0000, e}, {27'h000_0000, st});
  endtask

  // Both write channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    wq.push_back({r, 32'h0000_0000});
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    rq.push_back(e);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // Sends n measurement cycles; go drops at the edge of the last pulse
  task automatic send(input int n);
    @(posedge clk);
    go <= 1'b1;
    repeat (n) @(posedge clk iff mv === 1'b1);
    go <= 1'b0;
  endtask

  task automatic ms(input fps_phasor_type p, input logic [6:0] e);
    ph <= p;
    send(1);
    wt(4);
    sc(e);
  endtask

  // Bus answers are matched against the oldest noted expectation
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk("read word", rq.pop_front(), {rresp, rdata});
    if (bvalid === 1'b1 && bready === 1'b1) chk("write resp", wq.pop_front(), {bresp, 32'h0000_0000});
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Run needs about 1000 cycles; a hang is cut well beyond that
  initial begin
    wt(8000);
    mismatches++;
    final_report();
  end

  initial begin
    wt(5);
    reset <= 1'b0;
    wt(4);
    sc(7'h01);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_SLVERR);
    rd(ADDR_CTRL, {RESP_SLVERR, 32'h0000_0000});
    scope <= 1'b1;
    wt(4);
    rd(ADDR_CTRL, {RESP_OKAY, RST_CTRL});
    rd(ADDR_LOW_DLY, {RESP_OKAY, RST_DLY});
    rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
    wr(ADDR_STATUS, 32'h0000_0000, RESP_SLVERR);
    // Accurate method, current turned by 90 degrees; window starts empty
    wr(ADDR_CORR, 32'h4000_0000, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_0009, RESP_OKAY);
    ph <= prot;
    send(1);
    wt(4);
    rd(ADDR_POWER, {RESP_OKAY, 32'h0000_0064});
    send(15);
    wt(4);
    rd(ADDR_POWER, {RESP_OKAY, 32'h0000_0640});
    // Fast method on random phasors; correction must not apply
    wr(ADDR_CTRL, 32'h0000_000D, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      for (int f = 0; f < 4; f++) begin
        seed = lfsr(seed);
        rp[f*16 +: 16] = {{2{seed[15]}}, seed[15:2]};
      end
      ph <= rp;
      send(1);
      wt(4);
      rd(ADDR_POWER, {RESP_OKAY, pw(rp)});
    end
    // Park both stages idle before the short delays, whatever the random power was
    wr(ADDR_LOW_THR, 32'h0000_0064, RESP_OKAY);
    wr(ADDR_HIGH_THR, 32'h0000_03E8, RESP_OKAY);
    ms(p500, 7'h04);
    wr(ADDR_LOW_DLY, 32'h0000_0005, RESP_OKAY);
    wr(ADDR_HIGH_DLY, 32'h0000_FFFF, RESP_OKAY);
    ms(p50, 7'h0C);
    ms(p500, 7'h04);
    ms(p50, 7'h0C);
    wt(40);
    sc(7'h0C);
    wt(25);
    sc(7'h2C);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h0000_002C});
    // Each low-stage block in turn
    for (int b = 0; b < 4; b++) begin
      lpin[b] <= 1'b1;
      wt(8);
      sc(7'h04);
      lpin[b] <= 1'b0;
      wt(8);
      sc(7'h0C);
    end
    ms(p2000, 7'h14);
    wt(40);
    sc(7'h14);
    blk_high <= 1'b1;
    wt(8);
    sc(7'h04);
    blk_high <= 1'b0;
    blk_all  <= 1'b1;
    wt(8);
    sc(7'h02);
    blk_all <= 1'b0;
    wr(ADDR_HIGH_DLY, 32'h0000_0000, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0000_000E, RESP_OKAY);
    wt(40);
    sc(7'h14);
    wr(ADDR_CTRL, 32'h0000_000D, RESP_OKAY);
    wt(8);
    sc(7'h54);
    wr(ADDR_CTRL, 32'h0000_000C, RESP_OKAY);
    wt(8);
    sc(7'h01);
    // Mode code 3 is undefined and must read as off
    wr(ADDR_CTRL, 32'h0000_000F, RESP_OKAY);
    wt(8);
    sc(7'h01);
    // Per-unit thresholds scale by the nominal power
    wr(ADDR_CTRL, 32'h0000_000D, RESP_OKAY);
    ms(p50, 7'h0C);
    wr(ADDR_CTRL, 32'h0000_0005, RESP_OKAY);
    wt(8);
    sc(7'h54);
    final_report();
  end
endmodule

`default_nettype wire
